// >>> core/tssq_pkg.sv
/*
  Shared constants for the touch-screen serial sequencer: control byte
  fields, channel codes, serial frame counts.
  Assumes a 50 MHz system clock that oversamples the serial clock.
*/
`default_nettype none
package tssq_pkg;
  localparam int unsigned CTRL_BITS = 8;
  localparam int unsigned RES_BITS = 12;
  localparam int unsigned SAR_CYCLES = 12;
  localparam int unsigned TAIL_CYCLES = 3;
  // control byte field positions, msb first
  localparam int unsigned BIT_START = 7;
  localparam int unsigned BIT_CH_HI = 6;
  localparam int unsigned BIT_CH_LO = 4;
  localparam int unsigned BIT_MODE = 3;
  localparam int unsigned BIT_REF = 2;
  localparam int unsigned BIT_PD_HI = 1;
  localparam int unsigned BIT_PD_LO = 0;
  // bits received before the mux can be set (start + channel + mode)
  localparam logic [3:0] ACQ_AT_BITS = 4'h5;
  localparam logic [2:0] CH_Y = 3'h1;
  localparam logic [2:0] CH_X = 3'h5;
  localparam logic [2:0] CH_AUX = 3'h2;
  localparam logic [2:0] CH_PEN = 3'h6;
  localparam logic [3:0] CNT_CTRL_LAST = 4'h7;
  localparam logic [3:0] CNT_RESULT_LAST = 4'hC;
  localparam logic [3:0] CNT_TAIL_LAST = 4'h2;
  localparam logic [11:0] LSB_DIVISOR_M1 = 12'hFFF;
  localparam logic [15:0] PHASE_SEL_RESET = 16'h0000;
endpackage : tssq_pkg
`default_nettype wire

// >>> core/tssq_edge_sync.sv
/*
  Two-flop synchroniser with edge detection for one async input.
  Assumes the input toggles far slower than sys_clk_i.
*/
`default_nettype none
module tssq_edge_sync (
  input wire logic sys_clk_i, // system clock
  input wire logic rstn_i,    // async reset, active low
  input wire logic async_i,   // asynchronous level
  input wire logic rst_val_i, // unused tie guard, must be constant
  output logic level_o,       // synchronised level
  output logic rise_o,        // one-cycle pulse on rising edge
  output logic fall_o         // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tssq_sync_t;
  tssq_sync_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign level_o = st_ff.s2;
  assign rise_o = st_ff.s2 & ~st_ff.s3;
  assign fall_o = ~st_ff.s2 & st_ff.s3;
  logic unused_rst_val;
  assign unused_rst_val = rst_val_i;
endmodule // tssq_edge_sync
`default_nettype wire

// >>> core/tssq_sequencer.sv
/*
  Serial control and conversion sequencer of a 12-bit SAR touch ADC.
  Samples serial_clock, chip select and serial input with sys_clk_i,
  decodes the control byte, drives panel switches and hold/convert
  strobes, and shifts the result out msb first.
  Assumes the analog SAR comparator result arrives on sar_cmp_i and
  that the serial clock is much slower than sys_clk_i.
*/
`default_nettype none
// Overview of operation
// - control byte is shifted in over the first eight serial clocks
// - acquisition starts and panel switches turn on once mux bits known
// - three clocks later hold is taken, conversion entered, drivers may drop
// - successive approximation runs over the twelve following serial clocks
// - differential mode keeps panel drivers on throughout conversion
// - a thirteenth clock after conversion start outputs the last bit
// - three more clocks complete the byte; output low, otherwise ignored
// - channel and reference bits set mux, drivers, reference; 110 is pen state
// - measurement mode grounds lower right and powers upper left
// - Y measurement: lower left to ground, upper right to supply
// - X measurement: lower left to supply, upper right to ground
// - differential mode takes reference from the driven panel nodes
// - one code step equals reference divided by 4096
// - serial input is sampled on rising serial clock while selected
// - output changes on falling clock and floats while deselected
// - serial input ignored until a high start bit appears
// - byte order: start, channel, resolution, reference, power down
module tssq_sequencer (
  input wire logic sys_clk_i,          // 50 MHz system clock
  input wire logic rstn_i,             // async reset, active low
  input wire logic serial_clock_i,     // host serial clock pin
  input wire logic csn_i,              // chip select pin, active low
  input wire logic din_i,              // serial data input pin
  input wire logic sar_cmp_i,          // comparator: input above trial level
  input wire logic pen_touch_irq_n_i,  // pen touch state pin, active low
  output logic dout_o,                 // serial data output
  output logic dout_oe_o,              // serial data output enable
  output logic upper_left_driver_o,    // upper left to supply
  output logic upper_right_driver_o,   // upper right: 1 supply, 0 ground
  output logic upper_right_en_o,       // upper right switch on
  output logic lower_left_driver_o,    // lower left: 1 supply, 0 ground
  output logic lower_left_en_o,        // lower left switch on
  output logic lower_right_driver_o,   // lower right to ground
  output logic y_drive_enable_o,       // Y position switches
  output logic x_drive_enable_o,       // X position switches
  output logic aux_sel_o,              // mux on aux_analog_input
  output logic ref_from_panel_o,       // reference taken from panel nodes
  output logic sample_o,               // sample/hold tracking
  output logic sar_trial_o,            // comparator trial valid
  output logic [11:0] sar_code_o,      // trial code to the capacitor dac
  output logic [11:0] result_o,        // last completed result
  output logic mode_8bit_o,            // resolution select of last byte
  output logic [1:0] power_down_sel_o  // power-down bits of last byte
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CTRL = 5'b00010,
    ST_CONV = 5'b00100,
    ST_TAIL = 5'b01000,
    ST_DONE = 5'b10000
  } tssq_state_t;

  typedef struct packed {
    tssq_state_t state;
    logic [3:0] cnt;
    logic [7:0] ctrl;
    logic [11:0] sar;
    logic [11:0] res;
    logic [3:0] sar_idx;
    logic sampling;
    logic drv_on;
    logic dout;
    logic dout_oe;
    logic trial;
    logic [2:0] ch;
    logic ref_ser;
    logic mode8;
    logic [1:0] pd;
  } tssq_regs_t;

  tssq_regs_t r_ff, nxt_r;
  logic sclk_rise, sclk_fall, cs_lvl, din_lvl, pen_lvl;

  tssq_edge_sync u_sclk (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(serial_clock_i),
    .rst_val_i(1'b0),
    .level_o(),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  // csn, din and pen pass two flops before use
  logic [1:0] cs_s_ff, din_s_ff, pen_s_ff, cmp_s_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s_ff <= 2'h3;
      din_s_ff <= 2'h0;
      pen_s_ff <= 2'h3;
      cmp_s_ff <= 2'h0;
    end else begin
      cs_s_ff <= {cs_s_ff[0], csn_i};
      din_s_ff <= {din_s_ff[0], din_i};
      pen_s_ff <= {pen_s_ff[0], pen_touch_irq_n_i};
      cmp_s_ff <= {cmp_s_ff[0], sar_cmp_i};
    end
  end
  assign cs_lvl = ~cs_s_ff[1];
  assign din_lvl = din_s_ff[1];
  assign pen_lvl = ~pen_s_ff[1];

  function automatic logic needs_drive(input logic [2:0] ch);
    needs_drive = (ch == tssq_pkg::CH_Y) || (ch == tssq_pkg::CH_X);
  endfunction

  always_comb begin
    nxt_r = r_ff;
    nxt_r.trial = 1'b0;
    unique case (r_ff.state)
      ST_IDLE: begin
        if (cs_lvl && sclk_rise && din_lvl) begin
          nxt_r.state = ST_CTRL;
          nxt_r.ctrl = 8'h01;
          nxt_r.cnt = 4'h1;
        end
      end
      ST_CTRL: begin
        if (sclk_rise) begin
          nxt_r.ctrl = {r_ff.ctrl[6:0], din_lvl};
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt + 4'h1 == tssq_pkg::ACQ_AT_BITS) begin
            nxt_r.ch = {r_ff.ctrl[2:0]};
            nxt_r.mode8 = din_lvl;
            nxt_r.sampling = 1'b1;
            nxt_r.drv_on = needs_drive(r_ff.ctrl[2:0]);
          end
          if (r_ff.cnt + 4'h1 == tssq_pkg::ACQ_AT_BITS + 4'h1) begin
            nxt_r.ref_ser = din_lvl;
          end
          if (r_ff.cnt == tssq_pkg::CNT_CTRL_LAST) begin
            nxt_r.pd = {r_ff.ctrl[0], din_lvl};
            nxt_r.state = ST_CONV;
            nxt_r.cnt = 4'h0;
            nxt_r.sampling = 1'b0;
            nxt_r.drv_on = r_ff.drv_on & ~r_ff.ref_ser;
            nxt_r.sar = 12'h800;
            nxt_r.sar_idx = 4'hB;
          end
        end
      end
      ST_CONV: begin
        // one bit decision per serial clock
        if (sclk_rise && (r_ff.cnt != 4'h0)) begin
          nxt_r.trial = 1'b1;
          if (r_ff.ch == tssq_pkg::CH_PEN) begin
            nxt_r.sar[r_ff.sar_idx] = pen_lvl;
          end else begin
            nxt_r.sar[r_ff.sar_idx] = cmp_s_ff[1];
          end
          if (r_ff.sar_idx != 4'h0) begin
            nxt_r.sar[r_ff.sar_idx - 4'h1] = 1'b1;
            nxt_r.sar_idx = r_ff.sar_idx - 4'h1;
          end
        end
        // result out on falling edge, msb first
        if (sclk_fall) begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == 4'h0) begin
            nxt_r.dout = 1'b0;
          end else begin
            nxt_r.dout = r_ff.sar[4'hC - r_ff.cnt];
          end
          // thirteenth clock shows the last bit
          if (r_ff.cnt == tssq_pkg::CNT_RESULT_LAST) begin
            nxt_r.dout = r_ff.sar[0];
            nxt_r.res = r_ff.sar;
            nxt_r.drv_on = 1'b0;
            nxt_r.state = ST_TAIL;
            nxt_r.cnt = 4'h0;
          end
        end
      end
      ST_TAIL: begin
        // tail clocks drive low, else ignored
        if (sclk_fall) begin
          nxt_r.dout = 1'b0;
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == tssq_pkg::CNT_TAIL_LAST) begin
            nxt_r.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        nxt_r.dout = 1'b0;
        nxt_r.state = ST_IDLE;
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase
    nxt_r.dout_oe = cs_lvl;
    if (!cs_lvl) begin
      nxt_r.state = ST_IDLE;
      nxt_r.dout = 1'b0;
      nxt_r.sampling = 1'b0;
      nxt_r.drv_on = 1'b0;
      nxt_r.cnt = 4'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_ff <= '0;
      r_ff.state <= ST_IDLE;
      r_ff.ref_ser <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // panel switch decode, registered
  logic ul_ff, ur_ff, ur_en_ff, ll_ff, ll_en_ff, lr_ff, y_ff, x_ff, aux_ff, refp_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {ul_ff, ur_ff, ur_en_ff, ll_ff, ll_en_ff, lr_ff} <= 6'h00;
      {y_ff, x_ff, aux_ff, refp_ff} <= 4'h0;
    end else begin
      // upper left, lower right and corner enables follow drv_on, same for every channel
      ul_ff <= nxt_r.drv_on;
      lr_ff <= nxt_r.drv_on;
      ur_en_ff <= nxt_r.drv_on;
      ll_en_ff <= nxt_r.drv_on;
      // Y: ur supply, ll ground; X: reversed
      ur_ff <= nxt_r.drv_on & (nxt_r.ch == tssq_pkg::CH_Y);
      ll_ff <= nxt_r.drv_on & (nxt_r.ch == tssq_pkg::CH_X);
      y_ff <= nxt_r.drv_on & (nxt_r.ch == tssq_pkg::CH_Y);
      x_ff <= nxt_r.drv_on & (nxt_r.ch == tssq_pkg::CH_X);
      aux_ff <= (nxt_r.state != ST_IDLE) & (nxt_r.ch == tssq_pkg::CH_AUX);
      refp_ff <= ~nxt_r.ref_ser & needs_drive(nxt_r.ch);
    end
  end

  assign dout_o = r_ff.dout;
  assign dout_oe_o = r_ff.dout_oe;
  assign upper_left_driver_o = ul_ff;
  assign upper_right_driver_o = ur_ff;
  assign upper_right_en_o = ur_en_ff;
  assign lower_left_driver_o = ll_ff;
  assign lower_left_en_o = ll_en_ff;
  assign lower_right_driver_o = lr_ff;
  assign y_drive_enable_o = y_ff;
  assign x_drive_enable_o = x_ff;
  assign aux_sel_o = aux_ff;
  assign ref_from_panel_o = refp_ff;
  assign sample_o = r_ff.sampling;
  assign sar_trial_o = r_ff.trial;
  // 12-bit code, step = reference / (LSB_DIVISOR_M1 + 1)
  assign sar_code_o = r_ff.sar;
  assign result_o = r_ff.res;
  assign mode_8bit_o = r_ff.mode8;
  assign power_down_sel_o = r_ff.pd;

  property p_float_when_idle;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      cs_s_ff[1] |=> !dout_oe_o;
  endproperty
  a_float_when_idle: assert property (p_float_when_idle) else $error("dout not floated");

  property p_tail_low;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_ff.state == ST_TAIL) && sclk_fall |=> !dout_o;
  endproperty
  a_tail_low: assert property (p_tail_low) else $error("tail bit not low");

  property p_hold_at_conv;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_ff.state == ST_CONV) |-> !sample_o;
  endproperty
  a_hold_at_conv: assert property (p_hold_at_conv) else $error("sampling during convert");

  property p_ratio_drive;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_ff.state == ST_CONV) && !r_ff.ref_ser && needs_drive(r_ff.ch) && cs_lvl
      && !(sclk_fall && (r_ff.cnt == tssq_pkg::CNT_RESULT_LAST))
      |=> ul_ff;
  endproperty
  a_ratio_drive: assert property (p_ratio_drive) else $error("drivers dropped");

  property p_y_corners;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      y_drive_enable_o |-> upper_right_driver_o && !lower_left_driver_o && lower_right_driver_o;
  endproperty
  a_y_corners: assert property (p_y_corners) else $error("Y corners wrong");

  property p_x_corners;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      x_drive_enable_o |-> !upper_right_driver_o && lower_left_driver_o && upper_left_driver_o;
  endproperty
  a_x_corners: assert property (p_x_corners) else $error("X corners wrong");

  property p_start_gate;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_ff.state == ST_IDLE) && sclk_rise && !din_lvl |=> r_ff.state == ST_IDLE;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("started without start bit");

  property p_conv_entry;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_ff.state == ST_CTRL) && sclk_rise && r_ff.cnt == 4'h7 && cs_lvl
      |=> r_ff.state == ST_CONV && r_ff.sar == 12'h800;
  endproperty
  a_conv_entry: assert property (p_conv_entry) else $error("no conversion after byte");

  property p_aux_no_drive;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      aux_sel_o |-> !y_drive_enable_o && !x_drive_enable_o;
  endproperty
  a_aux_no_drive: assert property (p_aux_no_drive) else $error("aux with drivers");
endmodule // tssq_sequencer
`default_nettype wire

// >>> bench/tssq_host_model.sv
/*
  Host serial port model: drives the link clock, chip select and serial
  data in, and collects the serial reply of one frame.
  Assumes the 50 MHz bench clock; the link clock period is 8 of its cycles.
*/
`default_nettype none
module tssq_host_model (
  input wire logic sys_clk_i,  // bench clock
  input wire logic dout_i,     // serial data from the device
  output logic serial_clock_o, // link clock, low between frames
  output logic csn_o,          // chip select, active low
  output logic din_o           // serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_clock_o = 1'b0;
    csn_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask

  // lead zeros, control byte, then 16 reply clocks
  task automatic frame(input logic [7:0] cb, input int lead, output logic [15:0] rx);
    int k;
    rx = 16'h0000;
    csn_o = 1'b0;
    half();
    for (k = 0; k < lead + 24; k++) begin
      din_o = (k >= lead && k < lead + 8) ? cb[lead + 7 - k] : 1'b0;
      half();
      serial_clock_o = 1'b1;
      half();
      if (k >= lead + 8) rx = {rx[14:0], dout_i};
      serial_clock_o = 1'b0;
    end
    half();
    csn_o = 1'b1;
    half();
  endtask
endmodule // tssq_host_model
`default_nettype wire

// >>> bench/tb_top.sv
/*
  Self-checking bench of the serial sequencer: frames per channel code,
  switch map, serial reply and latched fields are compared.
  Assumes the host model drives the serial pins; comparator is modelled here.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CB [7] = '{8'h97, 8'h93, 8'hD7, 8'hD9, 8'hA7, 8'hE7, 8'hE7};
  localparam logic [11:0] VIN [7] = '{12'hFFF, 12'h001, 12'h800, 12'h5A3, 12'h3C7,
                                      12'h000, 12'h000};
  localparam logic [6:0] PEN_N = 7'h3F;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sar_cmp = 1'b0;
  logic pen_n = 1'b1;
  logic [11:0] vin = 12'h000;
  logic sclk, csn, din, dout, dout_oe, dout_pin;
  logic ul, urd, uren, lld, llen, lrd, ye, xe, aux, refp, smp, trial, m8;
  logic [11:0] code, result, exp;
  logic [1:0] pd;
  logic [15:0] rx, sw;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int trials = 0;
  int i;

  always #10 sys_clk = ~sys_clk;

  // released line shows the inverse of its last value
  assign dout_pin = dout_oe ? dout : ~dout;
  assign sw = {5'h00, ye, xe, aux, llen, lld, uren, urd, ul, lrd, refp, smp};

  always @(negedge sys_clk) sar_cmp <= (vin >= code);

  always @(posedge sys_clk) begin
    if (trial === 1'b1) trials <= trials + 1;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      summarize();
    end
  end

  tssq_host_model i_host (.sys_clk_i(sys_clk), .dout_i(dout_pin),
    .serial_clock_o(sclk), .csn_o(csn), .din_o(din));

  tssq_sequencer i_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .serial_clock_i(sclk),
    .csn_i(csn), .din_i(din), .sar_cmp_i(sar_cmp), .pen_touch_irq_n_i(pen_n),
    .dout_o(dout), .dout_oe_o(dout_oe), .upper_left_driver_o(ul),
    .upper_right_driver_o(urd), .upper_right_en_o(uren), .lower_left_driver_o(lld),
    .lower_left_en_o(llen), .lower_right_driver_o(lrd), .y_drive_enable_o(ye),
    .x_drive_enable_o(xe), .aux_sel_o(aux), .ref_from_panel_o(refp), .sample_o(smp),
    .sar_trial_o(trial), .sar_code_o(code), .result_o(result), .mode_8bit_o(m8),
    .power_down_sel_o(pd));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  // switch and reference state expected for a control byte
  function automatic logic [15:0] exp_sw(input logic [7:0] cb, input logic s);
    logic y, x, a, m;
    y = (cb[6:4] === tssq_pkg::CH_Y);
    x = (cb[6:4] === tssq_pkg::CH_X);
    a = (cb[6:4] === tssq_pkg::CH_AUX);
    m = y | x;
    return {5'h00, y, x, a, m, x, m, y, m, m, ~cb[2] & m, s};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    check("outputs in reset", {dout_oe, ye, xe, aux, refp, smp, ul, lrd, result[7:0]}, 16'h0000);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (i = 0; i < 7; i++) begin
      vin = VIN[i];
      pen_n = PEN_N[i];
      trials = 0;
      exp = (CB[i][6:4] === tssq_pkg::CH_PEN) ? {12{~PEN_N[i]}} : VIN[i];
      fork
        i_host.frame(CB[i], 2, rx);
        begin
          repeat (7) @(posedge sclk);
          repeat (3) @(negedge sys_clk);
          check("acquisition start", {15'h0000, smp}, 16'h0001);
          repeat (2) @(posedge sclk);
          repeat (2) @(negedge sys_clk);
          check("acquisition switches", sw, exp_sw(CB[i], 1'b1));
          check("output enable selected", {15'h0000, dout_oe}, 16'h0001);
          repeat (8) @(posedge sclk);
          repeat (2) @(negedge sys_clk);
          if (CB[i][2] === 1'b0) begin
            check("conversion switches", sw, exp_sw(CB[i], 1'b0));
          end else begin
            check("hold in conversion", {15'h0000, smp}, 16'h0000);
            check("single-ended conversion switches", sw, exp_sw(CB[i], 1'b0) & 16'h0100);
          end
        end
      join
      check("serial reply", rx, {1'b0, exp, 3'h0});
      check("result", {4'h0, result}, {4'h0, exp});
      check("bit decisions", trials[15:0], 16'h000C);
      check("byte fields", {13'h0000, m8, pd}, {13'h0000, CB[i][3], CB[i][1:0]});
      check("output enable idle", {15'h0000, dout_oe}, 16'h0000);
    end
    summarize();
  end
endmodule // tb_top
`default_nettype wire
